// *** logic/fsq_regs.svh ***
// timing and command constants for the dual byte flash sequencer
`ifndef FSQ_REGS_SVH
`define FSQ_REGS_SVH
// ---------------------------------------------------------------
// clock and bus timing
// ---------------------------------------------------------------
`define FSQ_CLK_NS       8
`define FSQ_WE_NS        32
`define FSQ_WE_CYC       ((`FSQ_WE_NS + `FSQ_CLK_NS - 1) / `FSQ_CLK_NS)
`define FSQ_RD_NS        32
`define FSQ_RD_CYC       ((`FSQ_RD_NS + `FSQ_CLK_NS - 1) / `FSQ_CLK_NS)
`define FSQ_VFY_NS       6000
`define FSQ_VFY_CYC      ((`FSQ_VFY_NS + `FSQ_CLK_NS - 1) / `FSQ_CLK_NS)
`define FSQ_PROG_NS      10000
`define FSQ_PROG_CYC     ((`FSQ_PROG_NS + `FSQ_CLK_NS - 1) / `FSQ_CLK_NS)
`define FSQ_ERASE_NS     10000000
// ---------------------------------------------------------------
// doubled command words, one byte per device, then byte, word, error code, address, timer and counter constants
// ---------------------------------------------------------------
`define FSQ_CMD_ERASE    16'h2020
`define FSQ_CMD_EVERIFY  16'hA0A0
`define FSQ_CMD_PROG     16'h4040
`define FSQ_CMD_PVERIFY  16'hC0C0
`define FSQ_CMD_RESET    16'hFFFF
`define FSQ_CMD_READ     16'h0000
`define FSQ_BYTE_RESET   8'hFF
`define FSQ_BYTE_ZERO    8'h00
`define FSQ_WORD_ERASED  16'hFFFF
`define FSQ_ERR_NONE     2'h0
`define FSQ_ADDR_ZERO    16'h0000
`define FSQ_TMR_ZERO     21'h000000
`define FSQ_CNT_ZERO     8'h00
`define FSQ_CNT_ONE      8'h01
`endif

// *** logic/fsq_pkg.sv ***
// types shared by the dual byte flash sequencer files
package fsq_pkg;
  // one word to program, with end-of-stream marker
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
    logic        last;
  } fsq_word_t;

  // pins toward the flash pair
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] dq_o;
    logic        dq_oe_n;
    logic        we_n;
    logic        oe_n;
  } fsq_pins_t;

  typedef enum logic [12:0] {
    S_IDLE     = 13'h0001,
    S_VPPON    = 13'h0002,
    S_FETCH    = 13'h0004,
    S_SETUP    = 13'h0008,
    S_OP       = 13'h0010,
    S_PULSE    = 13'h0020,
    S_VERIFY   = 13'h0040,
    S_SETTLE   = 13'h0080,
    S_READ     = 13'h0100,
    S_JUDGE    = 13'h0200,
    S_RESET    = 13'h0400,
    S_READMODE = 13'h0800,
    S_VPPOFF   = 13'h1000
  } fsq_state_t;
endpackage

// *** logic/fsq_buf.sv ***
// two-entry word buffer between the data source and the sequencer
`timescale 1ns/1ns
module fsq_buf
  import fsq_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire logic      nrst,
  input  wire logic      in_valid,
  output logic           in_ready,
  input  wire fsq_word_t in_word,
  output logic           out_valid,
  input  wire logic      out_ready,
  output fsq_word_t      out_word
);
  fsq_word_t  mem_q [2];
  logic       wr_ptr_q;
  logic       rd_ptr_q;
  logic [1:0] cnt_q;
  logic       push;
  logic       pop;

  // ---------------------------------------------------------------
  // handshakes
  // ---------------------------------------------------------------
  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_word  = mem_q[rd_ptr_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage, written by index
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_word;
    end
  end

  // pointers and fill level; a stalled reader lets it fill
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      if (push) wr_ptr_q <= ~wr_ptr_q;
      if (pop)  rd_ptr_q <= ~rd_ptr_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  a_buf_no_over : assert property (@(posedge clk_sys) disable iff (!nrst)
    cnt_q != 2'h3) else $error("buffer level out of range");
endmodule // fsq_buf

// *** logic/fsq_seq.sv ***
// erase and program sequencer for a word built from two byte-wide flashes
`timescale 1ns/1ns
`include "fsq_regs.svh"
module fsq_seq
  import fsq_pkg::*;
#(
  parameter logic [7:0]  ERASE_MAX = 8'd100,
  parameter logic [7:0]  PROG_MAX  = 8'd25,
  parameter logic [20:0] ERASE_CYC = 21'(`FSQ_ERASE_NS / `FSQ_CLK_NS)
)(
  input  wire logic      clk_sys,
  input  wire logic      nrst,
  input  wire logic      start_erase,
  input  wire logic      start_prog,
  input  wire logic [15:0] last_location,
  input  wire logic      word_valid,
  output logic           word_ready,
  input  wire fsq_word_t word_in,
  output logic           busy,
  output logic           done,
  output logic [1:0]     err_code,
  input  wire logic      vpp_ok,
  output logic           vpp_en_n,
  output fsq_pins_t      pins,
  input  wire logic [15:0] dq_i
);

  fsq_state_t  state_q;
  logic [20:0] tmr_q;
  logic        erase_mode_q;
  logic [15:0] target_location;
  logic [15:0] erase_cmd_word;
  logic [15:0] verify_cmd_word;
  logic [15:0] write_cmd_word;
  logic [15:0] word_to_write;
  logic [15:0] write_readback_word;
  logic [7:0]  lower_half_pulse_count;
  logic [7:0]  upper_half_pulse_count;
  logic        last_word_q;
  logic [1:0]  flag_q;
  logic        rst_sent_q;
  logic        done_q;
  logic        vpp_en_n_q;
  fsq_pins_t   pins_q;
  logic        buf_valid;
  logic        buf_pop;
  fsq_word_t   buf_word;
  logic [15:0] expected_word;
  logic        lo_ok;
  logic        hi_ok;
  logic        word_ok;
  logic [1:0]  flag_d;
  logic [7:0]  max_cnt;
  logic [15:0] wr_data;
  logic        is_wr;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // one half passes when its byte, other byte forced to zero, matches
  function automatic logic half_match(input logic [7:0] got, input logic [7:0] want);
    logic [15:0] g;
    g = {`FSQ_BYTE_ZERO, got};
    return g == {`FSQ_BYTE_ZERO, want};
  endfunction

  function automatic logic over_limit(input logic [7:0] cnt, input logic [7:0] lim);
    return (cnt + `FSQ_CNT_ONE) >= lim;
  endfunction

  // ---------------------------------------------------------------
  // word buffer in the data path
  // ---------------------------------------------------------------
  assign buf_pop = (state_q == S_FETCH) && buf_valid;

  fsq_buf i_fsq_buf (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .in_valid  (word_valid),
    .in_ready  (word_ready),
    .in_word   (word_in),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_word  (buf_word)
  );

  // ---------------------------------------------------------------
  // verify judgement
  // ---------------------------------------------------------------
  // erase compares against all ones, program against the stored data
  assign expected_word = erase_mode_q ? `FSQ_WORD_ERASED : word_to_write;
  assign word_ok = (write_readback_word == expected_word);
  assign lo_ok   = half_match(write_readback_word[7:0], expected_word[7:0]);
  assign hi_ok   = half_match(write_readback_word[15:8], expected_word[15:8]);
  assign max_cnt = erase_mode_q ? ERASE_MAX : PROG_MAX;
  assign flag_d  = flag_q
                 | {!hi_ok && over_limit(upper_half_pulse_count, max_cnt),
                    !lo_ok && over_limit(lower_half_pulse_count, max_cnt)};

  // bus write data for each write state
  always_comb begin
    is_wr   = 1'b1;
    wr_data = `FSQ_CMD_READ;
    case (state_q)
      S_SETUP:    wr_data = erase_mode_q ? erase_cmd_word : write_cmd_word;
      S_OP:       wr_data = erase_mode_q ? erase_cmd_word : word_to_write;
      S_VERIFY:   wr_data = verify_cmd_word;
      S_RESET:    wr_data = `FSQ_CMD_RESET;
      S_READMODE: wr_data = `FSQ_CMD_READ;
      default:    is_wr   = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // state and timer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= S_IDLE;
      tmr_q   <= `FSQ_TMR_ZERO;
    end else begin
      if (tmr_q != `FSQ_TMR_ZERO) tmr_q <= tmr_q - 21'h1;
      case (state_q)
        S_IDLE: begin
          if (start_erase || start_prog) state_q <= S_VPPON;
        end
        S_VPPON: begin
          // no command goes out before the supply reports settled
          if (vpp_ok) begin
            state_q <= erase_mode_q ? S_SETUP : S_FETCH;
            tmr_q   <= 21'(`FSQ_WE_CYC);
          end
        end
        S_FETCH: begin
          if (buf_valid) begin
            state_q <= S_SETUP;
            tmr_q   <= 21'(`FSQ_WE_CYC);
          end
        end
        S_SETUP: begin
          if (tmr_q == `FSQ_TMR_ZERO) begin
            state_q <= S_OP;
            tmr_q   <= 21'(`FSQ_WE_CYC);
          end
        end
        S_OP: begin
          if (tmr_q == `FSQ_TMR_ZERO) begin
            state_q <= S_PULSE;
            tmr_q   <= erase_mode_q ? ERASE_CYC : 21'(`FSQ_PROG_CYC);
          end
        end
        S_PULSE: begin
          if (tmr_q == `FSQ_TMR_ZERO) begin
            state_q <= S_VERIFY;
            tmr_q   <= 21'(`FSQ_WE_CYC);
          end
        end
        S_VERIFY: begin
          if (tmr_q == `FSQ_TMR_ZERO) begin
            state_q <= S_SETTLE;
            tmr_q   <= 21'(`FSQ_VFY_CYC);
          end
        end
        S_SETTLE: begin
          if (tmr_q == `FSQ_TMR_ZERO) begin
            state_q <= S_READ;
            tmr_q   <= 21'(`FSQ_RD_CYC);
          end
        end
        S_READ: begin
          if (tmr_q == `FSQ_TMR_ZERO) state_q <= S_JUDGE;
        end
        S_JUDGE: begin
          tmr_q <= 21'(`FSQ_WE_CYC);
          if (word_ok) begin
            if (erase_mode_q) begin
              // next address only needs a verify, no new erase
              state_q <= (target_location == last_location) ? S_RESET : S_VERIFY;
            end else begin
              state_q <= last_word_q ? S_RESET : S_FETCH;
            end
          end else if (flag_d != `FSQ_ERR_NONE) begin
            state_q <= S_RESET;
          end else begin
            state_q <= S_SETUP;
          end
        end
        S_RESET: begin
          if (tmr_q == `FSQ_TMR_ZERO) begin
            state_q <= S_READMODE;
            tmr_q   <= 21'(`FSQ_WE_CYC);
          end
        end
        S_READMODE: begin
          if (tmr_q == `FSQ_TMR_ZERO) state_q <= S_VPPOFF;
        end
        S_VPPOFF: state_q <= S_IDLE;
        default:  state_q <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // working variables: address, commands, counters, flag
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      erase_mode_q           <= 1'b0;
      target_location        <= `FSQ_ADDR_ZERO;
      erase_cmd_word         <= `FSQ_CMD_ERASE;
      verify_cmd_word        <= `FSQ_CMD_EVERIFY;
      write_cmd_word         <= `FSQ_CMD_PROG;
      word_to_write          <= `FSQ_WORD_ERASED;
      last_word_q            <= 1'b0;
      lower_half_pulse_count <= `FSQ_CNT_ZERO;
      upper_half_pulse_count <= `FSQ_CNT_ZERO;
      flag_q                 <= `FSQ_ERR_NONE;
    end else if (state_q == S_IDLE && (start_erase || start_prog)) begin
      erase_mode_q           <= start_erase;
      target_location        <= `FSQ_ADDR_ZERO;
      erase_cmd_word         <= `FSQ_CMD_ERASE;
      verify_cmd_word        <= start_erase ? `FSQ_CMD_EVERIFY : `FSQ_CMD_PVERIFY;
      lower_half_pulse_count <= `FSQ_CNT_ZERO;
      upper_half_pulse_count <= `FSQ_CNT_ZERO;
      flag_q                 <= `FSQ_ERR_NONE;
    end else if (buf_pop) begin
      // fresh word: default commands and counters
      target_location        <= buf_word.addr;
      word_to_write          <= buf_word.data;
      last_word_q            <= buf_word.last;
      write_cmd_word         <= `FSQ_CMD_PROG;
      verify_cmd_word        <= `FSQ_CMD_PVERIFY;
      lower_half_pulse_count <= `FSQ_CNT_ZERO;
      upper_half_pulse_count <= `FSQ_CNT_ZERO;
    end else if (state_q == S_JUDGE) begin
      if (word_ok) begin
        // both halves good: no mask change, defaults back for next address
        if (erase_mode_q) begin
          erase_cmd_word         <= `FSQ_CMD_ERASE;
          verify_cmd_word        <= `FSQ_CMD_EVERIFY;
          target_location        <= target_location + 16'h1;
          lower_half_pulse_count <= `FSQ_CNT_ZERO;
          upper_half_pulse_count <= `FSQ_CNT_ZERO;
        end
      end else begin
        // a verified half gets the reset code in each command word (S_OP program data stays unmasked), so one strobe serves both
        if (lo_ok) begin
          erase_cmd_word[7:0]  <= `FSQ_BYTE_RESET;
          write_cmd_word[7:0]  <= `FSQ_BYTE_RESET;
          verify_cmd_word[7:0] <= `FSQ_BYTE_RESET;
        end else begin
          lower_half_pulse_count <= lower_half_pulse_count + `FSQ_CNT_ONE;
        end
        if (hi_ok) begin
          erase_cmd_word[15:8]  <= `FSQ_BYTE_RESET;
          write_cmd_word[15:8]  <= `FSQ_BYTE_RESET;
          verify_cmd_word[15:8] <= `FSQ_BYTE_RESET;
        end else begin
          upper_half_pulse_count <= upper_half_pulse_count + `FSQ_CNT_ONE;
        end
        flag_q <= flag_d;
      end
    end
  end

  // ---------------------------------------------------------------
  // pin drivers, all from flip-flops
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pins_q              <= '{addr: `FSQ_ADDR_ZERO, dq_o: `FSQ_CMD_READ,
                               dq_oe_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
      write_readback_word <= `FSQ_CMD_READ;
    end else begin
      pins_q.addr    <= target_location;
      pins_q.dq_o    <= wr_data;
      pins_q.dq_oe_n <= !is_wr;
      // strobe released one cycle before data lets go, for hold
      pins_q.we_n    <= !(is_wr && tmr_q != `FSQ_TMR_ZERO);
      pins_q.oe_n    <= !(state_q == S_READ);
      if (state_q == S_READ && tmr_q == `FSQ_TMR_ZERO) write_readback_word <= dq_i;
    end
  end

  // supply enable, done pulse and reset-before-off tracking
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      vpp_en_n_q <= 1'b1;
      done_q     <= 1'b0;
      rst_sent_q <= 1'b0;
    end else begin
      done_q <= (state_q == S_VPPOFF);
      if (state_q == S_IDLE && (start_erase || start_prog)) begin
        vpp_en_n_q <= 1'b0;
        rst_sent_q <= 1'b0;
      end
      if (state_q == S_READMODE && tmr_q == `FSQ_TMR_ZERO) rst_sent_q <= 1'b1;
      if (state_q == S_VPPOFF) vpp_en_n_q <= 1'b1;
    end
  end

  assign pins     = pins_q;
  assign vpp_en_n = vpp_en_n_q;
  assign done     = done_q;
  assign err_code = flag_q;
  assign busy     = (state_q != S_IDLE);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_setup_needs_vpp : assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(state_q == S_SETUP) |-> $past(vpp_ok) && !vpp_en_n_q)
    else $error("command issued before supply settled");
  a_supply_on_pulse : assert property (@(posedge clk_sys) disable iff (!nrst)
    (state_q == S_PULSE) |-> !vpp_en_n_q) else $error("pulse without supply");
  a_off_after_reset : assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(vpp_en_n_q) |-> rst_sent_q) else $error("supply off before read mode");
  a_restore_defaults : assert property (@(posedge clk_sys) disable iff (!nrst)
    (state_q == S_JUDGE && erase_mode_q && word_ok) |=>
      erase_cmd_word == `FSQ_CMD_ERASE && verify_cmd_word == `FSQ_CMD_EVERIFY)
    else $error("commands not restored");
  a_low_masked : assert property (@(posedge clk_sys) disable iff (!nrst)
    (state_q == S_JUDGE && !word_ok && lo_ok) |=>
      verify_cmd_word[7:0] == `FSQ_BYTE_RESET) else $error("low half not masked");
  a_low_count_step : assert property (@(posedge clk_sys) disable iff (!nrst)
    (state_q == S_JUDGE && !word_ok && !lo_ok) |=>
      lower_half_pulse_count == $past(lower_half_pulse_count) + `FSQ_CNT_ONE)
    else $error("low counter did not step");
  a_error_stops : assert property (@(posedge clk_sys) disable iff (!nrst)
    (state_q == S_JUDGE && !word_ok && flag_d != `FSQ_ERR_NONE) |=>
      state_q == S_RESET && err_code == $past(flag_d)
      ##[1:40] done && err_code != `FSQ_ERR_NONE)
    else $error("limit did not end the run");
  a_zero_flag_retry : assert property (@(posedge clk_sys) disable iff (!nrst)
    (state_q == S_JUDGE && !word_ok && flag_d == `FSQ_ERR_NONE) |=> state_q == S_SETUP)
    else $error("no further pulse");
  a_read_window : assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(state_q == S_READ) |-> $past(state_q == S_SETTLE) ##1 !pins.oe_n)
    else $error("read without verify settle");

  c_erase_done : cover property (@(posedge clk_sys) disable iff (!nrst)
    done && erase_mode_q && err_code == `FSQ_ERR_NONE);
  c_prog_done : cover property (@(posedge clk_sys) disable iff (!nrst)
    done && !erase_mode_q && err_code == `FSQ_ERR_NONE);
  c_half_masked : cover property (@(posedge clk_sys) disable iff (!nrst)
    state_q == S_JUDGE && !word_ok && lo_ok);
  c_both_over : cover property (@(posedge clk_sys) disable iff (!nrst)
    done && err_code == 2'h3);
endmodule // fsq_seq

// *** sim/fsq_flash_model.sv ***
// behavioural pair of byte-wide flash devices sharing one write strobe
`timescale 1ns/1ns
module fsq_flash_model
  import fsq_pkg::*;
(
  input  wire fsq_pins_t  pins,
  input  wire logic       vpp_en_n,
  input  wire logic [7:0] need_lo,
  input  wire logic [7:0] need_hi,
  output logic [15:0]     dq_i,
  output int              n_wr,
  output int              n_av,
  output int              n_mask,
  output logic [15:0]     off_cmd
);
  logic [7:0]  mem [2][16];
  logic [7:0]  cmd [2];
  int          ep [2];
  int          pp [2];
  logic [15:0] paddr;
  logic [15:0] rd_q;

  // clear array, counters and command state between scenarios
  task automatic wipe(logic [7:0] v);
    foreach (mem[h, a]) mem[h][a] = v;
    cmd = '{8'hFF, 8'hFF};
    ep = '{0, 0};
    pp = '{0, 0};
    n_wr = 0;
    n_av = 0;
    n_mask = 0;
    paddr = 16'hFFFF;
    rd_q = 16'h0000;
  endtask

  // ---------------------------------------------------------------
  // command decode, one byte lane per device
  // ---------------------------------------------------------------
  // writes only count while the supply is on, so early strobes show up
  always @(posedge pins.we_n) begin
    // a strobe with the host's data drivers off carries no command
    if (vpp_en_n === 1'b0 && pins.dq_oe_n === 1'b0) begin
      n_wr++;
      if (pins.dq_o == 16'hA0A0) n_av++;
      if ((pins.dq_o[15:8] == 8'hFF) != (pins.dq_o[7:0] == 8'hFF)) n_mask++;
      for (int h = 0; h < 2; h++) begin
        logic [7:0] b;
        b = pins.dq_o[8*h +: 8];
        if (cmd[h] == 8'h20 && b == 8'h20) cmd[h] = 8'h21;
        else if (cmd[h] == 8'h21 && b == 8'hA0) begin
          // verify ends the running pulse; chip erased once enough pulses
          ep[h]++;
          if (ep[h] >= (h ? need_hi : need_lo)) begin
            for (int a = 0; a < 16; a++) mem[h][a] = 8'hFF;
          end
          cmd[h] = b;
        end else if (cmd[h] == 8'h40) begin
          if (pins.addr != paddr) pp[h] = 0;
          pp[h]++;
          if (pp[h] >= (h ? need_hi : need_lo)) mem[h][pins.addr[3:0]] &= b;
          cmd[h] = 8'h41;
        end else cmd[h] = b;
      end
      if (cmd[0] == 8'h41 || cmd[1] == 8'h41) paddr = pins.addr;
    end
  end

  // released bus shows the inverse of the last word, never a stale copy
  always @(posedge pins.oe_n) rd_q = {mem[1][pins.addr[3:0]], mem[0][pins.addr[3:0]]};
  always @* dq_i = pins.oe_n ? ~rd_q : {mem[1][pins.addr[3:0]], mem[0][pins.addr[3:0]]};
  always @(posedge vpp_en_n) off_cmd = {cmd[1], cmd[0]};
endmodule // fsq_flash_model

// *** sim/tb_fsq_seq.sv ***
// self-checking bench for the dual byte flash sequencer
`timescale 1ns/1ns
module tb_fsq_seq
  import fsq_pkg::*;
();
  logic        clk_sys, nrst, start_erase, start_prog, word_valid, word_ready;
  logic        busy, done, vpp_ok, vpp_en_n;
  logic [15:0] last_location, dq_i, off_cmd;
  logic [1:0]  err_code;
  logic [7:0]  need_lo, need_hi;
  fsq_word_t   word_in;
  fsq_pins_t   pins;
  int          n_wr, n_av, n_mask, mismatches, n_tests;

  // small limits keep every run short
  fsq_seq #(.ERASE_MAX(8'd3), .PROG_MAX(8'd3), .ERASE_CYC(21'd20)) i_fsq_seq (
    .clk_sys(clk_sys), .nrst(nrst), .start_erase(start_erase), .start_prog(start_prog),
    .last_location(last_location), .word_valid(word_valid), .word_ready(word_ready),
    .word_in(word_in), .busy(busy), .done(done), .err_code(err_code), .vpp_ok(vpp_ok),
    .vpp_en_n(vpp_en_n), .pins(pins), .dq_i(dq_i));
  fsq_flash_model i_fsq_flash_model (.pins(pins), .vpp_en_n(vpp_en_n), .need_lo(need_lo),
    .need_hi(need_hi), .dq_i(dq_i), .n_wr(n_wr), .n_av(n_av), .n_mask(n_mask),
    .off_cmd(off_cmd));

  initial begin
    clk_sys = 0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // holds valid and data until the buffer has taken the word
  task automatic push(fsq_word_t w);
    @(negedge clk_sys);
    word_in = w;
    word_valid = 1;
    while (word_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    word_valid = 0;
  endtask

  // one start pulse, then a bounded wait for the done pulse
  task automatic run(logic prog, logic [7:0] nl, logic [7:0] nh);
    int cyc;
    need_lo = nl;
    need_hi = nh;
    @(negedge clk_sys);
    start_erase = !prog;
    start_prog = prog;
    @(negedge clk_sys);
    start_erase = 0;
    start_prog = 0;
    cyc = 0;
    while (done !== 1'b1 && cyc < 30000) begin
      @(posedge clk_sys);
      #1;
      cyc++;
    end
    check("run end", 16'd1, 16'(done));
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    repeat (5) @(negedge clk_sys);
    check("strobe idle", 16'd1, 16'(pins.we_n));
    check("supply idle", 16'd1, 16'(vpp_en_n));
    nrst = 1;
  endtask

  task automatic t_erase_basic();
    i_fsq_flash_model.wipe(8'h00);
    fork
      run(1'b0, 8'd1, 8'd1);
      begin
        repeat (40) @(negedge clk_sys);
        check("writes before supply", 16'd0, 16'(n_wr));
        check("supply on", 16'd0, 16'(vpp_en_n));
        vpp_ok = 1;
      end
    join
    check("plain verifies", 16'd4, 16'(n_av));
    check("masked writes", 16'd0, 16'(n_mask));
    check("last command", 16'h0000, off_cmd);
    check("supply off", 16'd1, 16'(vpp_en_n));
    check("erase code", 16'd0, 16'(err_code));
  endtask

  // slow upper half: lower half masked, defaults back for next address
  task automatic t_erase_mask();
    i_fsq_flash_model.wipe(8'h00);
    last_location = 16'h0001;
    run(1'b0, 8'd1, 8'd2);
    check("default verifies", 16'd2, 16'(n_av));
    check("masked writes", 16'd3, 16'(n_mask));
    check("erase code", 16'd0, 16'(err_code));
  endtask

  // reset in mid-run while the supply is still settling
  task automatic t_abort();
    i_fsq_flash_model.wipe(8'h00);
    vpp_ok = 0;
    @(negedge clk_sys);
    start_erase = 1;
    @(negedge clk_sys);
    start_erase = 0;
    repeat (3) @(negedge clk_sys);
    check("busy before abort", 16'd1, 16'(busy));
    check("supply before abort", 16'd0, 16'(vpp_en_n));
    check("writes before supply", 16'd0, 16'(n_wr));
    nrst = 0;
    repeat (2) @(negedge clk_sys);
    check("supply after abort", 16'd1, 16'(vpp_en_n));
    check("idle after abort", 16'd0, 16'(busy));
    nrst = 1;
    repeat (2) @(negedge clk_sys);
    check("strobe after abort", 16'd1, 16'(pins.we_n));
    check("done after abort", 16'd0, 16'(done));
    check("ready after abort", 16'd1, 16'(word_ready));
    vpp_ok = 1;
  endtask

  // buffer fills and stalls, then drains while upper half is slow
  task automatic t_prog();
    logic [15:0] d [3] = '{16'h5AC3, 16'h3C96, 16'h965A};
    i_fsq_flash_model.wipe(8'hFF);
    push('{16'h0001, d[0], 1'b0});
    push('{16'h0002, d[1], 1'b0});
    check("buffer full", 16'd0, 16'(word_ready));
    fork
      push('{16'h0003, d[2], 1'b1});
      run(1'b1, 8'd1, 8'd2);
    join
    for (int a = 0; a < 3; a++) begin
      check("word", d[a], {i_fsq_flash_model.mem[1][a+1], i_fsq_flash_model.mem[0][a+1]});
    end
    check("masked writes", 16'd6, 16'(n_mask));
    check("program code", 16'd0, 16'(err_code));
    check("last command", 16'h0000, off_cmd);
  endtask

  // every error code, for erase and for program
  task automatic t_errors();
    for (int p = 0; p < 2; p++)
      for (int c = 1; c < 4; c++) begin
        i_fsq_flash_model.wipe(p ? 8'hFF : 8'h00);
        if (p) push('{16'h0004, 16'h5AC3, 1'b1});
        vpp_ok = 0;
        fork
          run(p[0], c[0] ? 8'd9 : 8'd1, c[1] ? 8'd9 : 8'd1);
          begin
            repeat (8) @(negedge clk_sys);
            check("writes before supply", 16'd0, 16'(n_wr));
            vpp_ok = 1;
          end
        join
        repeat (5) @(negedge clk_sys);
        check("error code", 16'(c), 16'(err_code));
        check("idle after limit", 16'd0, 16'(busy));
      end
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    {start_erase, start_prog, word_valid, vpp_ok} = '0;
    last_location = 16'h0003;
    word_in = '0;
    need_lo = 8'd1;
    need_hi = 8'd1;
    mismatches = 0;
    n_tests = 0;
    nrst = 0;
    i_fsq_flash_model.wipe(8'h00);
    t_reset();
    t_erase_basic();
    t_erase_mask();
    t_abort();
    t_prog();
    t_errors();
    give_verdict();
  end

  // a hang counts as a mismatch and ends the run the usual way
  initial begin
    repeat (90000) @(posedge clk_sys);
    mismatches++;
    give_verdict();
  end
endmodule // tb_fsq_seq
